// File: rtl/usart_core_regs.svh
`ifndef USART_CORE_REGS_SVH
`define USART_CORE_REGS_SVH

// Register byte offsets on the APB bus
`define OFF_CONFIG         12'h000
`define OFF_CONTROL        12'h004
`define OFF_STATUS         12'h008
`define OFF_INT_EN_SET     12'h00C
`define OFF_INT_EN_CLEAR   12'h010
`define OFF_RX_BUFFER      12'h014
`define OFF_RX_BUFFER_STAT 12'h018
`define OFF_TX_BUFFER      12'h01C
`define OFF_BAUD_DIVISOR   12'h020
`define OFF_INT_STATUS     12'h024

// Reset values
`define CONFIG_RESET       16'h0000
`define BAUD_RESET         16'h0000

// Status bit positions
`define ST_RX_READY        0
`define ST_RX_IDLE         1
`define ST_TX_READY        2
`define ST_TX_IDLE         3
`define ST_CTS_LEVEL       4
`define ST_DELTA_CTS       5
`define ST_OVERRUN         8
`define ST_START_SEEN      10
`define ST_FRAME_ERR       13
`define ST_NOISE           15
`define ST_ADDR_SENT       16
`define ST_TX_CLK_PEND     17

// Control bit position
`define CTL_TX_DISABLE     6

// Sticky (write one to clear) and implemented status bits
`define STICKY_MASK        18'h3_A520
`define INTEN_MASK         18'h3_A53F

// Oversampling timing counts
`define OS_LAST            4'hF
`define VOTE_FIRST         4'h7
`define VOTE_LAST          4'h9

`endif

// File: rtl/usart_core_pkg.sv
package usart_core_pkg;

   // Receiver sequencing
   typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP}
      rx_state_type;

   // Transmitter sequencing
   typedef enum logic [1:0] {TX_IDLE, TX_DATA, TX_STOP}
      tx_state_type;

   // Configuration word, bit 15 down to bit 0
   typedef struct packed {
      logic       spare15;
      logic       sync_master_select;
      logic [1:0] spare13;
      logic       sync_enable;
      logic       spare10;
      logic       flow_gate_enable;
      logic [1:0] spare8;
      logic       stop_two;
      logic [1:0] spare5;
      logic [1:0] data_length;
      logic       spare1;
      logic       enable;
   } config_type;

endpackage

// File: rtl/usart_core.sv
// The placing of the registers and register access over APB were decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "usart_core_regs.svh"

module usart_core (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        prescaler_tick,
   input  wire logic        serial_receive_line,
   input  wire logic        clear_to_send_input_n,
   input  wire logic        serial_clock_pin_in,
   input  wire logic        wake_start_logic_enable,
   output logic             serial_transmit_line,
   output logic             request_to_send_output_n,
   output logic             serial_clock_pin_out,
   output logic             serial_clock_pin_oe_n,
   output logic             interrupt_request,
   output logic             deep_wake_request
);

   ////////////////////////////////////////////////////////////////
   // Declarations

   usart_core_pkg::config_type   cfg_q;     // Configuration
   usart_core_pkg::rx_state_type rx_st_q;   // Receiver state
   usart_core_pkg::tx_state_type tx_st_q;   // Transmitter state
   logic [15:0] baud_divisor_value_q;       // Baud divisor
   logic        tx_disable_q;               // Software tx hold
   logic [17:0] interrupt_enable_set_q;     // Interrupt enables
   logic [17:0] sticky_q;                   // Sticky status flags
   logic [8:0]  receive_data_buffer_q;      // Received character
   logic        rx_ready_q;                 // Buffer full
   logic [8:0]  transmit_data_buffer_q;     // Holding register
   logic        tx_full_q;                  // Holding occupied
   logic [2:0]  rxd_sync_q;                 // Receive line sync
   logic [2:0]  cts_sync_q;                 // Clear to send sync
   logic [2:0]  sclk_sync_q;                // Slave clock sync
   logic [15:0] brg_cnt_q;                  // Baud down counter
   logic        sclk_out_q;                 // Generated clock
   logic [3:0]  rx_os_q;                    // Receive 16x phase
   logic [3:0]  tx_os_q;                    // Transmit 16x phase
   logic [1:0]  votes_q;                    // Earlier two samples
   logic [8:0]  rx_sh_q;                    // Receive shifter
   logic [3:0]  rx_cnt_q;                   // Receive bit count
   logic [8:0]  tx_sh_q;                    // Transmit shifter
   logic [3:0]  tx_cnt_q;                   // Transmit bit count
   logic        tx_stop_cnt_q;              // Stop bits sent
   logic        tx_line_q;                  // Transmit pin
   logic        rts_n_q;                    // Request to send
   logic        irq_q;                      // Interrupt output
   logic        deep_wake_q;                // Deep wake output
   logic [31:0] prdata_q;                   // Read data
   logic [31:0] rd_mux;                     // Read selection
   logic        mapped;                     // Address decoded
   logic [17:0] status;                     // Full status vector
   logic [17:0] int_status;                 // Enabled status
   logic [17:0] events;                     // Sticky set pulses

   logic en, sync_mode, master, slave;
   logic access, wr, rd, rd_buf;
   logic brg_tick, m_rise, s_rise, s_fall;
   logic rx_line, cts_line, rx_fall;
   logic rx_strobe, tx_strobe, rx_bit, vote, noisy;
   logic [3:0]  nbits;
   logic [15:0] half;
   logic rx_done, rx_load, overrun, start_seen, frame_err;
   logic cts_ok, tx_go, tx_load, addr_sent, tx_clk_pend;

   ////////////////////////////////////////////////////////////////
   // Mode and character shape

   assign en        = cfg_q.enable;
   assign sync_mode = cfg_q.sync_enable;
   assign master    = sync_mode & cfg_q.sync_master_select;
   assign slave     = sync_mode & ~cfg_q.sync_master_select;

   assign nbits = (cfg_q.data_length == 2'h0) ? 4'h7 :
                  (cfg_q.data_length == 2'h1) ? 4'h8 : 4'h9;

   ////////////////////////////////////////////////////////////////
   // Input synchronisers

   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         rxd_sync_q  <= 3'h7;
         cts_sync_q  <= 3'h7;
         sclk_sync_q <= 3'h0;
      end
      else
      begin
         rxd_sync_q  <= {rxd_sync_q[1:0], serial_receive_line};
         cts_sync_q  <= {cts_sync_q[1:0], clear_to_send_input_n};
         sclk_sync_q <= {sclk_sync_q[1:0], serial_clock_pin_in};
      end

   // Stage 0 feeds only stage 1; edges use stages 1 and 2
   assign rx_line  = rxd_sync_q[1];
   assign cts_line = cts_sync_q[1];
   assign rx_fall  = ~rxd_sync_q[1] & rxd_sync_q[2];
   assign s_rise   = slave & sclk_sync_q[1] & ~sclk_sync_q[2];
   assign s_fall   = slave & ~sclk_sync_q[1] & sclk_sync_q[2];

   ////////////////////////////////////////////////////////////////
   // Baud generator

   // shared prescaler arrives as a pulse, none kept here
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         brg_cnt_q <= 16'h0000;
      else if (!en)
         brg_cnt_q <= 16'h0000;
      else if (prescaler_tick)
         brg_cnt_q <= (brg_cnt_q == 16'h0000) ?
                      baud_divisor_value_q - 16'h0001 :
                      brg_cnt_q - 16'h0001;

   // one tick per divisor prescaler ticks
   assign brg_tick = en & prescaler_tick & (brg_cnt_q == 16'h0000);
   // Rising edge mid-period; divisors below 2 give no rise
   assign half   = {1'b0, baud_divisor_value_q[15:1]};
   assign m_rise = master & en & prescaler_tick &
                   (half != 16'h0000) & (brg_cnt_q == half);

   // clock period equals divisor ticks
   // Held while the pin is released, so an idle pin never moves
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         sclk_out_q <= 1'b0;
      else if (!(en & cfg_q.sync_master_select))
         sclk_out_q <= sclk_out_q;
      else if (brg_tick)
         sclk_out_q <= 1'b0;
      else if (prescaler_tick & (brg_cnt_q == half))
         sclk_out_q <= 1'b1;

   assign serial_clock_pin_oe_n = ~(en & cfg_q.sync_master_select);
   assign serial_clock_pin_out  = sclk_out_q;

   ////////////////////////////////////////////////////////////////
   // Bit strobes

   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         rx_os_q <= 4'h0;
         tx_os_q <= 4'h0;
         votes_q <= 2'h3;
      end
      else
      begin
         if (rx_st_q == usart_core_pkg::RX_IDLE && rx_fall)
            rx_os_q <= 4'h0;
         else if (brg_tick)
            rx_os_q <= rx_os_q + 4'h1;
         if (brg_tick)
            tx_os_q <= tx_os_q + 4'h1;
         // Samples at phases 7 and 8; phase 9 is live
         if (brg_tick && rx_os_q >= `VOTE_FIRST &&
             rx_os_q < `VOTE_LAST)
            votes_q <= {votes_q[0], rx_line};
      end

   assign vote  = (votes_q[1] & votes_q[0]) |
                  (votes_q[1] & rx_line) | (votes_q[0] & rx_line);
   assign noisy = ~((votes_q[1] == votes_q[0]) &&
                    (votes_q[0] == rx_line));

   // master shifts once per baud period
   assign rx_strobe = ~sync_mode ?
                      (brg_tick & (rx_os_q == `VOTE_LAST)) :
                      (m_rise | s_rise);
   assign tx_strobe = ~sync_mode ?
                      (brg_tick & (tx_os_q == `OS_LAST)) :
                      master ? brg_tick : s_fall;
   assign rx_bit    = sync_mode ? rx_line : vote;

   ////////////////////////////////////////////////////////////////
   // Receiver

   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         rx_st_q  <= usart_core_pkg::RX_IDLE;
         rx_sh_q  <= 9'h000;
         rx_cnt_q <= 4'h0;
      end
      else if (!en)
         rx_st_q <= usart_core_pkg::RX_IDLE;
      else
         case (rx_st_q)
            usart_core_pkg::RX_IDLE:
               if (!sync_mode && rx_fall)
                  rx_st_q <= usart_core_pkg::RX_START;
               else if (sync_mode && rx_strobe && !rx_bit)
               begin
                  rx_st_q  <= usart_core_pkg::RX_DATA;
                  rx_cnt_q <= 4'h0;
               end
            usart_core_pkg::RX_START:
               if (rx_strobe)
               begin
                  rx_st_q  <= rx_bit ? usart_core_pkg::RX_IDLE :
                                       usart_core_pkg::RX_DATA;
                  rx_cnt_q <= 4'h0;
               end
            usart_core_pkg::RX_DATA:
               if (rx_strobe)
               begin
                  // Least significant bit arrives first
                  rx_sh_q  <= {rx_bit, rx_sh_q[8:1]};
                  rx_cnt_q <= rx_cnt_q + 4'h1;
                  if (rx_cnt_q == nbits - 4'h1)
                     rx_st_q <= usart_core_pkg::RX_STOP;
               end
            default:
               // Only the first stop bit is checked
               if (rx_strobe)
                  rx_st_q <= usart_core_pkg::RX_IDLE;
         endcase

   assign rx_done    = rx_strobe & (rx_st_q == usart_core_pkg::RX_STOP);
   assign frame_err  = rx_done & ~rx_bit;
   assign start_seen = rx_strobe & ~rx_bit &
                       ((rx_st_q == usart_core_pkg::RX_START) |
                        (sync_mode &
                         (rx_st_q == usart_core_pkg::RX_IDLE)));
   // a full buffer keeps its first character
   assign rx_load = rx_done & (~rx_ready_q | rd_buf);
   assign overrun = rx_done & rx_ready_q & ~rd_buf;

   // receive buffer and its full flag
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         receive_data_buffer_q <= 9'h000;
         rx_ready_q            <= 1'b0;
      end
      else
      begin
         if (rx_load)
            receive_data_buffer_q <= rx_sh_q >> (4'h9 - nbits);
         // New character wins over a same-cycle read
         rx_ready_q <= rx_load | (rx_ready_q & ~rd_buf);
      end

   ////////////////////////////////////////////////////////////////
   // Transmitter

   // low from the remote means ready
   assign cts_ok  = ~cfg_q.flow_gate_enable | ~cts_line;
   assign tx_go   = tx_full_q & cts_ok & ~tx_disable_q;
   assign tx_load = en & tx_strobe & tx_go &
                    (tx_st_q == usart_core_pkg::TX_IDLE);
   assign addr_sent   = tx_load & (nbits == 4'h9) &
                        transmit_data_buffer_q[8];
   assign tx_clk_pend = s_fall & tx_full_q;

   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         tx_st_q       <= usart_core_pkg::TX_IDLE;
         tx_sh_q       <= 9'h000;
         tx_cnt_q      <= 4'h0;
         tx_stop_cnt_q <= 1'b0;
         tx_line_q     <= 1'b1;
      end
      else if (!en)
      begin
         tx_st_q   <= usart_core_pkg::TX_IDLE;
         tx_line_q <= 1'b1;
      end
      else if (tx_strobe)
         case (tx_st_q)
            usart_core_pkg::TX_IDLE:
               if (tx_go)
               begin
                  tx_sh_q   <= transmit_data_buffer_q;
                  tx_cnt_q  <= 4'h0;
                  tx_line_q <= 1'b0;
                  tx_st_q   <= usart_core_pkg::TX_DATA;
               end
            usart_core_pkg::TX_DATA:
            begin
               tx_line_q <= tx_sh_q[0];
               tx_sh_q   <= {1'b0, tx_sh_q[8:1]};
               tx_cnt_q  <= tx_cnt_q + 4'h1;
               if (tx_cnt_q == nbits - 4'h1)
               begin
                  tx_stop_cnt_q <= 1'b0;
                  tx_st_q       <= usart_core_pkg::TX_STOP;
               end
            end
            default:
            begin
               tx_line_q     <= 1'b1;
               tx_stop_cnt_q <= 1'b1;
               if (!cfg_q.stop_two || tx_stop_cnt_q)
                  tx_st_q <= usart_core_pkg::TX_IDLE;
            end
         endcase

   assign serial_transmit_line = tx_line_q;

   ////////////////////////////////////////////////////////////////
   // Bus decode

   assign access = psel & penable;
   assign wr     = access & pwrite & mapped;
   assign rd     = access & ~pwrite & mapped;
   assign rd_buf = rd & ((paddr == `OFF_RX_BUFFER) |
                         (paddr == `OFF_RX_BUFFER_STAT));
   assign pready  = 1'b1;
   assign pslverr = access & ~mapped;

   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         transmit_data_buffer_q <= 9'h000;
         tx_full_q              <= 1'b0;
      end
      else
      begin
         if (wr && paddr == `OFF_TX_BUFFER)
            transmit_data_buffer_q <= pwdata[8:0];
         // Disable resets the transmitter
         tx_full_q <= en & ((wr && paddr == `OFF_TX_BUFFER) |
                            (tx_full_q & ~tx_load));
      end

   // Configuration, control, divisor and enables
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         cfg_q                  <= `CONFIG_RESET;
         baud_divisor_value_q   <= `BAUD_RESET;
         tx_disable_q           <= 1'b0;
         interrupt_enable_set_q <= 18'h0_0000;
      end
      else if (wr)
      begin
         if (paddr == `OFF_CONFIG)
            cfg_q <= usart_core_pkg::config_type'(pwdata[15:0]);
         else if (paddr == `OFF_CONTROL)
            tx_disable_q <= pwdata[`CTL_TX_DISABLE];
         else if (paddr == `OFF_BAUD_DIVISOR)
            baud_divisor_value_q <= pwdata[15:0];
         else if (paddr == `OFF_INT_EN_SET)
            interrupt_enable_set_q <= interrupt_enable_set_q |
                                      (pwdata[17:0] & `INTEN_MASK);
         else if (paddr == `OFF_INT_EN_CLEAR)
            interrupt_enable_set_q <= interrupt_enable_set_q &
                                      ~pwdata[17:0];
      end

   ////////////////////////////////////////////////////////////////
   // Status and interrupt

   // sticky wake sources recorded as events; level bits 0 to 4 are not
   always_comb
   begin
      events                  = 18'h0_0000;
      events[`ST_DELTA_CTS]   = cts_sync_q[1] ^ cts_sync_q[2];
      events[`ST_OVERRUN]     = overrun;
      events[`ST_START_SEEN]  = start_seen;
      events[`ST_FRAME_ERR]   = frame_err;
      events[`ST_NOISE]       = rx_done & ~sync_mode & noisy;
      events[`ST_ADDR_SENT]   = addr_sent;
      events[`ST_TX_CLK_PEND] = tx_clk_pend;
   end

   // sticky flags; set wins over clear
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         sticky_q <= 18'h0_0000;
      else if (wr && paddr == `OFF_STATUS)
         sticky_q <= (sticky_q & ~pwdata[17:0] | events) &
                     `STICKY_MASK;
      else
         sticky_q <= (sticky_q | events) & `STICKY_MASK;

   always_comb
   begin
      status                = sticky_q;
      status[`ST_RX_READY]  = rx_ready_q;
      status[`ST_RX_IDLE]   = rx_st_q == usart_core_pkg::RX_IDLE;
      status[`ST_TX_READY]  = ~tx_full_q;
      status[`ST_TX_IDLE]   = ~tx_full_q &
                              (tx_st_q == usart_core_pkg::TX_IDLE);
      status[`ST_CTS_LEVEL] = cts_line;
   end

   // each event gated by its enable
   assign int_status = status & interrupt_enable_set_q;

   // Outputs registered to keep them glitch-free
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         irq_q       <= 1'b0;
         deep_wake_q <= 1'b0;
         rts_n_q     <= 1'b1;
      end
      else
      begin
         // any enabled interrupt wakes from sleep
         irq_q       <= en & (|int_status);
         // slave-mode wake toward the start logic
         deep_wake_q <= en & slave & wake_start_logic_enable &
                        (|int_status);
         // low while enabled and the buffer has room
         rts_n_q     <= ~(en & ~rx_ready_q);
      end

   assign interrupt_request        = irq_q;
   assign deep_wake_request        = deep_wake_q;
   assign request_to_send_output_n = rts_n_q;

   ////////////////////////////////////////////////////////////////
   // Read path

   // Address decode and read selection
   always_comb
   begin
      mapped = 1'b1;
      rd_mux = 32'h0000_0000;
      if (paddr == `OFF_CONFIG)
         rd_mux[15:0] = cfg_q;
      else if (paddr == `OFF_CONTROL)
         rd_mux[`CTL_TX_DISABLE] = tx_disable_q;
      else if (paddr == `OFF_STATUS)
         rd_mux[17:0] = status;
      else if (paddr == `OFF_INT_EN_SET)
         rd_mux[17:0] = interrupt_enable_set_q;
      else if (paddr == `OFF_INT_EN_CLEAR)
         rd_mux = 32'h0000_0000;
      else if (paddr == `OFF_RX_BUFFER)
         rd_mux[8:0] = receive_data_buffer_q;
      else if (paddr == `OFF_RX_BUFFER_STAT)
         rd_mux = {status[15:0], 7'h00, receive_data_buffer_q};
      else if (paddr == `OFF_TX_BUFFER)
         rd_mux[8:0] = transmit_data_buffer_q;
      else if (paddr == `OFF_BAUD_DIVISOR)
         rd_mux[15:0] = baud_divisor_value_q;
      else if (paddr == `OFF_INT_STATUS)
         rd_mux[17:0] = int_status;
      else
         mapped = 1'b0;
   end

   // Captured in the setup cycle, stable through access
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         prdata_q <= 32'h0000_0000;
      else if (psel && !penable && !pwrite)
         prdata_q <= rd_mux;

   assign prdata = prdata_q;

endmodule

`default_nettype wire

// File: dv/usart_core_assertions.sv
`timescale 1ns/100ps
`default_nettype none
// Port-level checks on bus answers, wake-up and line timing
module usart_core_checker (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic [11:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        wake_start_logic_enable,
   input wire logic        serial_transmit_line,
   input wire logic        serial_clock_pin_out,
   input wire logic        serial_clock_pin_oe_n,
   input wire logic        interrupt_request,
   input wire logic        deep_wake_request
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   ready_always_a:
      assert property (pready) else $error("pready low");
   err_idle_a:
      assert property (!(psel && penable) |-> !pslverr)
      else $error("pslverr outside access");
   err_unmapped_a:
      assert property (psel && penable && paddr > 12'h024 |-> pslverr)
      else $error("unmapped access not refused");
   // Read data only moves after a setup cycle
   read_hold_a:
      assert property (!(psel && !penable) |=> $stable(prdata))
      else $error("prdata moved");
   wake_irq_a:
      assert property (deep_wake_request |-> interrupt_request)
      else $error("wake without interrupt");
   wake_gate_a:
      assert property (deep_wake_request |-> $past(wake_start_logic_enable))
      else $error("wake while not enabled");
   start_bit_a:
      assert property ($fell(serial_transmit_line) |=> !serial_transmit_line)
      else $error("start bit too short");
   // Undriven clock pin must stand still
   clock_still_a:
      assert property (serial_clock_pin_oe_n && $past(serial_clock_pin_oe_n)
                       |-> $stable(serial_clock_pin_out))
      else $error("clock moved while released");
   cover property ($fell(serial_transmit_line));
   cover property ($rose(interrupt_request));
   cover property (pslverr);
endmodule
bind usart_core usart_core_checker chk (.*);
`default_nettype wire

// File: dv/remote_serial_model.sv
`timescale 1ns/100ps
`default_nettype none
// Remote party: drives receive data, ready level and slave clock
module remote_serial_model (
   input  wire logic pclk,
   output logic      serial_receive_line,
   output logic      clear_to_send_input_n,
   output logic      serial_clock_pin_in
);
   // Idle line high, not ready until told
   initial
   begin
      serial_receive_line = 1'b1;
      clear_to_send_input_n = 1'b1;
      serial_clock_pin_in = 1'b0;
   end
   task set_ready(input logic rdy);
      @(posedge pclk);
      clear_to_send_input_n <= !rdy;
   endtask
   // start, eight bits LSB first, stop
   task send(input logic [7:0] d, input int bit_cyc);
      logic [9:0] f;
      f = {1'b1, d, 1'b0};
      for (int i = 0; i < 10; i++)
      begin
         @(posedge pclk);
         serial_receive_line <= f[i];
         repeat (bit_cyc - 1) @(posedge pclk);
      end
   endtask
   // master clock on the pin; low outside frames
   task clock_frame(input logic [7:0] d);
      logic [9:0] f;
      f = {1'b1, d, 1'b0};
      for (int i = 0; i < 10; i++)
      begin
         @(posedge pclk);
         serial_receive_line <= f[i];
         repeat (4) @(posedge pclk);
         serial_clock_pin_in <= 1'b1;
         repeat (4) @(posedge pclk);
         serial_clock_pin_in <= 1'b0;
      end
   endtask
endmodule
`default_nettype wire

// File: dv/usart_core_tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "usart_core_regs.svh"
module usart_core_tb;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic prescaler_tick, serial_receive_line, clear_to_send_input_n;
   logic serial_clock_pin_in, wake_start_logic_enable;
   logic serial_transmit_line, request_to_send_output_n;
   logic serial_clock_pin_out, serial_clock_pin_oe_n;
   logic interrupt_request, deep_wake_request;
   int   err_total, compares, n;
   usart_core DUT (.*);
   remote_serial_model remote (.*);
   initial
   begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   // Tick every other cycle: bit of divisor 1 is 32 cycles
   always @(posedge pclk) prescaler_tick <= ~prescaler_tick;
   task chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp)
      begin
         err_total++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // One bus transfer, held until pready at an edge
   task apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
         @(posedge pclk);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   // Sample a whole frame at mid-bit
   task tx_frame(input logic [7:0] d);
      logic [9:0] f;
      f = {1'b1, d, 1'b0};
      n = 0;
      while (serial_transmit_line !== 1'b0 && n < 400)
      begin
         @(posedge pclk);
         n++;
      end
      repeat (16) @(posedge pclk);
      for (int i = 0; i < 10; i++)
      begin
         chk(serial_transmit_line, f[i]);
         repeat (32) @(posedge pclk);
      end
   endtask
   task t_reset;
      apb(0, `OFF_STATUS, 0);
      chk(rd, 32'h0000_001E);
      chk(request_to_send_output_n, 1);
      apb(0, 12'h028, 0);
      chk(er, 1);
      chk(rd, 0);
   endtask
   // Gate off: ready level high is ignored
   task t_tx;
      apb(1, `OFF_BAUD_DIVISOR, 1);
      apb(1, `OFF_CONFIG, 32'h0000_0005);
      chk(serial_clock_pin_oe_n, 1);
      apb(1, `OFF_TX_BUFFER, 32'h0000_00A5);
      chk(request_to_send_output_n, 0);
      tx_frame(8'hA5);
   endtask
   // Gate on: held while remote not ready
   task t_flow;
      apb(1, `OFF_CONFIG, 32'h0000_0205);
      apb(1, `OFF_TX_BUFFER, 32'h0000_003C);
      n = 0;
      repeat (300)
      begin
         @(posedge pclk);
         n += !serial_transmit_line;
      end
      chk(n, 0);
      remote.set_ready(1);
      tx_frame(8'h3C);
   endtask
   // Receive raises the enabled flag; masked one stays quiet
   task t_rx;
      wake_start_logic_enable <= 1'b1;
      apb(1, `OFF_INT_EN_SET, 1);
      remote.send(8'hC3, 32);
      repeat (40) @(posedge pclk);
      chk(interrupt_request, 1);
      chk(deep_wake_request, 0);
      apb(0, `OFF_RX_BUFFER, 0);
      chk(rd, 32'h0000_00C3);
      @(posedge pclk);
      chk(interrupt_request, 0);
      apb(1, `OFF_INT_EN_CLEAR, 1);
      remote.send(8'h5A, 32);
      repeat (40) @(posedge pclk);
      chk(interrupt_request, 0);
      apb(0, `OFF_RX_BUFFER, 0);
      chk(rd, 32'h0000_005A);
   endtask
   // Slave clocked by the remote; full buffer keeps the first
   task t_slave;
      apb(1, `OFF_CONFIG, 32'h0000_0805);
      apb(1, `OFF_INT_EN_SET, 1);
      remote.clock_frame(8'h96);
      repeat (4) @(posedge pclk);
      chk(deep_wake_request, 1);
      remote.clock_frame(8'h69);
      apb(0, `OFF_RX_BUFFER, 0);
      chk(rd, 32'h0000_0096);
      apb(0, `OFF_STATUS, 0);
      chk(rd[`ST_OVERRUN], 1);
   endtask
   task stop_test;
      if (err_total == 0 && compares > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   initial
   begin
      repeat (20000) @(posedge pclk);
      err_total++;
      stop_test();
   end
   initial
   begin
      {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      {prescaler_tick, wake_start_logic_enable} = '0;
      err_total = 0;
      compares = 0;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_reset();
      t_tx();
      t_flow();
      t_rx();
      t_slave();
      stop_test();
   end
endmodule
`default_nettype wire
